//--- inc/bstap_pkg.sv
// Overview of operation
// R1: Standard test port with state machine, instruction register and data registers.
// R2: Only TCK, TMS, TDI, TDO; tester resets the port by holding TMS high.
// R3: TMS and TDI are taken on each rising TCK edge.
// R4: TDO changes only on falling TCK edges.
// R5: Test logic works only while test mode is high; otherwise pins are normal.
// R6: Codes 0000 and ffff select bypass; fff8 is sample/preload on boundary cells.
// R7: Code ffe8 is extest, ffef is clamp, ffcf is highz.
// R8: Code fffe selects the identification register and shifts its value out.
// R9: Every digital pin has boundary cells; crystal pins are not in the chain.
// R10: Test-Logic-Reset loads the identification instruction and frees the pins.
// R11: Code fffd and unknown codes act as bypass.
package bstap_pkg;
	localparam int IR_LEN = 16;
	localparam int DR_LEN = 32;
	localparam int NPIN = 8;
	localparam int BSR_LEN = 3 * NPIN;
	localparam logic [15:0] OP_BYPASS0 = 16'h0000;
	localparam logic [15:0] OP_BYPASS1 = 16'hffff;
	localparam logic [15:0] OP_SAMPLE = 16'hfff8;
	localparam logic [15:0] OP_EXTEST = 16'hffe8;
	localparam logic [15:0] OP_CLAMP = 16'hffef;
	localparam logic [15:0] OP_IDCODE = 16'hfffe;
	localparam logic [15:0] OP_HIGHZ = 16'hffcf;
	localparam logic [15:0] OP_INTSEL = 16'hfffd;
	localparam logic [15:0] IR_CAPTURE = 16'h0001;
	// identification value is arbitrary; bit 0 must be one
	localparam logic [31:0] ID_VALUE = 32'h0a5c_0001;
	localparam logic [5:0] LEN_BYP = 6'h01;
	localparam logic [5:0] LEN_ID = 6'h20;
	localparam logic [5:0] LEN_BSR = 6'h18;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} bstap_state_t;

	// test port pins as seen by the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic test_mode;
	} bstap_jtag_t;

	// one group of shared digital pins
	typedef struct packed {
		logic [NPIN-1:0] data;
		logic [NPIN-1:0] oe;
	} bstap_pins_t;
endpackage

//--- src/bstap_sync.sv
module bstap_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

//--- src/bstap_top.sv
module bstap_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// test port pins
	input wire bstap_pkg::bstap_jtag_t jtag,
	output logic tdo,
	output logic tdo_oe,
	// core side of the shared digital pins
	input wire bstap_pkg::bstap_pins_t core,
	output logic [bstap_pkg::NPIN-1:0] core_in,
	// pad side of the shared digital pins
	input wire logic [bstap_pkg::NPIN-1:0] pad_in,
	output bstap_pkg::bstap_pins_t pad
);
	typedef struct packed {
		bstap_pkg::bstap_state_t st;
		logic [bstap_pkg::IR_LEN-1:0] ir_sh;
		logic [bstap_pkg::IR_LEN-1:0] ir;
		logic [bstap_pkg::DR_LEN-1:0] dr;
		logic [bstap_pkg::BSR_LEN-1:0] bsr;
		logic tdo;
		logic tdo_oe;
		bstap_pkg::bstap_pins_t pad;
		logic [bstap_pkg::NPIN-1:0] cin;
		logic tck_d;
	} bstap_regs_t;

	bstap_regs_t r_reg;
	bstap_regs_t r_next;
	bstap_pkg::bstap_jtag_t js;
	logic [bstap_pkg::NPIN-1:0] pin_s;
	logic rise;
	logic fall;
	logic [5:0] dr_len;
	logic sel_bsr;
	logic sel_id;

	// pins from outside pass two flops first
	bstap_sync #(.W(4 + bstap_pkg::NPIN)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d({jtag, pad_in}),
		.q({js, pin_s})
	);

	// edges of the sampled test clock
	assign rise = js.tck & ~r_reg.tck_d;
	assign fall = ~js.tck & r_reg.tck_d;

	// instruction decode; unknown and private codes fall to bypass
	always_comb begin
		sel_bsr = 1'b0;
		sel_id = 1'b0;
		dr_len = bstap_pkg::LEN_BYP; // [R11]
		case (r_reg.ir)
			bstap_pkg::OP_SAMPLE, bstap_pkg::OP_EXTEST: begin // [R6] [R7]
				sel_bsr = 1'b1;
				dr_len = bstap_pkg::LEN_BSR;
			end
			bstap_pkg::OP_IDCODE: begin // [R8]
				sel_id = 1'b1;
				dr_len = bstap_pkg::LEN_ID;
			end
			default: begin
				sel_bsr = 1'b0; // [R6] bypass, clamp, highz, private
			end
		endcase
	end

	// next state of the tap controller
	function automatic bstap_pkg::bstap_state_t tap_next(bstap_pkg::bstap_state_t s, logic m);
		case (s)
			bstap_pkg::TLR: tap_next = m ? bstap_pkg::TLR : bstap_pkg::RTI;
			bstap_pkg::RTI: tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
			bstap_pkg::SEL_DR: tap_next = m ? bstap_pkg::SEL_IR : bstap_pkg::CAP_DR;
			bstap_pkg::CAP_DR: tap_next = m ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
			bstap_pkg::SH_DR: tap_next = m ? bstap_pkg::EX1_DR : bstap_pkg::SH_DR;
			bstap_pkg::EX1_DR: tap_next = m ? bstap_pkg::UPD_DR : bstap_pkg::PAU_DR;
			bstap_pkg::PAU_DR: tap_next = m ? bstap_pkg::EX2_DR : bstap_pkg::PAU_DR;
			bstap_pkg::EX2_DR: tap_next = m ? bstap_pkg::UPD_DR : bstap_pkg::SH_DR;
			bstap_pkg::UPD_DR: tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
			bstap_pkg::SEL_IR: tap_next = m ? bstap_pkg::TLR : bstap_pkg::CAP_IR;
			bstap_pkg::CAP_IR: tap_next = m ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
			bstap_pkg::SH_IR: tap_next = m ? bstap_pkg::EX1_IR : bstap_pkg::SH_IR;
			bstap_pkg::EX1_IR: tap_next = m ? bstap_pkg::UPD_IR : bstap_pkg::PAU_IR;
			bstap_pkg::PAU_IR: tap_next = m ? bstap_pkg::EX2_IR : bstap_pkg::PAU_IR;
			bstap_pkg::EX2_IR: tap_next = m ? bstap_pkg::UPD_IR : bstap_pkg::SH_IR;
			bstap_pkg::UPD_IR: tap_next = m ? bstap_pkg::SEL_DR : bstap_pkg::RTI;
			default: tap_next = bstap_pkg::TLR;
		endcase
	endfunction

	// whole next state
	always_comb begin
		r_next = r_reg;
		r_next.tck_d = js.tck;
		r_next.cin = pin_s;
		if (!js.test_mode) begin
			r_next.st = bstap_pkg::TLR; // [R5]
			r_next.ir = bstap_pkg::OP_IDCODE;
			r_next.tdo = 1'b0;
			r_next.tdo_oe = 1'b0;
		end else begin
			if (rise) begin
				r_next.st = tap_next(r_reg.st, js.tms); // [R1] [R2] [R3]
				case (r_reg.st)
					bstap_pkg::CAP_IR: r_next.ir_sh = bstap_pkg::IR_CAPTURE;
					bstap_pkg::SH_IR: r_next.ir_sh = {js.tdi, r_reg.ir_sh[15:1]}; // [R3]
					bstap_pkg::CAP_DR: begin
						if (sel_id) begin
							r_next.dr = bstap_pkg::ID_VALUE; // [R8]
						end else if (sel_bsr) begin
							r_next.dr = {8'h00, core.oe, core.data, pin_s}; // [R9]
						end else begin
							r_next.dr = 32'h0000_0000; // [R6] [R11]
						end
					end
					bstap_pkg::SH_DR: begin
						for (int i = 0; i < bstap_pkg::DR_LEN; i++) begin
							if (i == 32'(dr_len) - 1) begin
								r_next.dr[i] = js.tdi; // [R3]
							end else if (i < bstap_pkg::DR_LEN - 1) begin
								r_next.dr[i] = r_reg.dr[i+1];
							end else begin
								r_next.dr[i] = 1'b0;
							end
						end
					end
					default: begin
						r_next.dr = r_reg.dr;
					end
				endcase
			end
			if (fall) begin
				// tdo and updates move on the falling edge
				r_next.tdo = (r_reg.st == bstap_pkg::SH_IR) ? r_reg.ir_sh[0] : r_reg.dr[0]; // [R4]
				r_next.tdo_oe = (r_reg.st == bstap_pkg::SH_IR) || (r_reg.st == bstap_pkg::SH_DR);
				if (r_reg.st == bstap_pkg::UPD_IR) begin
					r_next.ir = r_reg.ir_sh; // [R1]
				end
				if (r_reg.st == bstap_pkg::UPD_DR && sel_bsr) begin
					r_next.bsr = r_reg.dr[bstap_pkg::BSR_LEN-1:0]; // [R6] [R7]
				end
			end
			if (r_reg.st == bstap_pkg::TLR) begin
				r_next.ir = bstap_pkg::OP_IDCODE; // [R10]
			end
		end
		// pad drive from the current instruction
		r_next.pad = core; // [R5] [R10]
		if (js.test_mode) begin
			case (r_reg.ir)
				bstap_pkg::OP_EXTEST, bstap_pkg::OP_CLAMP: begin // [R7]
					r_next.pad.data = r_reg.bsr[2*bstap_pkg::NPIN-1:bstap_pkg::NPIN];
					r_next.pad.oe = r_reg.bsr[3*bstap_pkg::NPIN-1:2*bstap_pkg::NPIN];
				end
				bstap_pkg::OP_HIGHZ: r_next.pad.oe = '0; // [R7]
				default: r_next.pad = core;
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg <= '{st: bstap_pkg::TLR, ir: bstap_pkg::OP_IDCODE, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign tdo = r_reg.tdo;
	assign tdo_oe = r_reg.tdo_oe;
	assign pad = r_reg.pad;
	assign core_in = r_reg.cin;

	// helper: rising edges seen with tms high in a row
	logic [2:0] tms_run;
	always_ff @(posedge ref_clk) begin
		if (rst || !js.test_mode) begin
			tms_run <= 3'h0;
		end else if (rise) begin
			tms_run <= !js.tms ? 3'h0 : (tms_run == 3'h5 ? 3'h5 : tms_run + 3'h1);
		end
	end

	sequence s_upd_ir;
		r_reg.st == bstap_pkg::UPD_IR && fall && js.test_mode;
	endsequence

	sequence s_cap_dr(logic [15:0] op);
		r_reg.st == bstap_pkg::CAP_DR && rise && js.test_mode && r_reg.ir == op;
	endsequence

	property p_ir_update;
		@(posedge ref_clk) disable iff (rst)
		s_upd_ir |=> r_reg.ir == $past(r_reg.ir_sh);
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("ir not updated"); // [R1]

	property p_tms_reset;
		@(posedge ref_clk) disable iff (rst)
		tms_run == 3'h5 |-> r_reg.st == bstap_pkg::TLR || r_next.st == bstap_pkg::TLR;
	endproperty
	a_tms_reset: assert property (p_tms_reset) else $error("five tms ones no reset"); // [R2]

	property p_rise_sample;
		@(posedge ref_clk) disable iff (rst)
		r_reg.st == bstap_pkg::TLR && rise && js.test_mode && !js.tms |=> r_reg.st == bstap_pkg::RTI;
	endproperty
	a_rise_sample: assert property (p_rise_sample) else $error("tms not taken"); // [R3]

	property p_tdo_fall;
		@(posedge ref_clk) disable iff (rst)
		js.test_mode && $changed(r_reg.tdo) |-> $past(fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge"); // [R4]

	property p_normal_pins;
		@(posedge ref_clk) disable iff (rst)
		!js.test_mode [*2] |=> pad == $past(core) && r_reg.st == bstap_pkg::TLR;
	endproperty
	a_normal_pins: assert property (p_normal_pins) else $error("pins not released"); // [R5]

	property p_bypass;
		@(posedge ref_clk) disable iff (rst)
		s_cap_dr(bstap_pkg::OP_BYPASS1) or s_cap_dr(bstap_pkg::OP_BYPASS0) |=> r_reg.dr[0] == 1'b0;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass capture wrong"); // [R6]

	property p_highz;
		@(posedge ref_clk) disable iff (rst)
		js.test_mode && r_reg.ir == bstap_pkg::OP_HIGHZ |=> pad.oe == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("highz drives pins"); // [R7]

	property p_idcode;
		@(posedge ref_clk) disable iff (rst)
		s_cap_dr(bstap_pkg::OP_IDCODE) |=> r_reg.dr == bstap_pkg::ID_VALUE;
	endproperty
	a_idcode: assert property (p_idcode) else $error("id value not captured"); // [R8]

	property p_extest;
		@(posedge ref_clk) disable iff (rst)
		js.test_mode && r_reg.ir == bstap_pkg::OP_EXTEST && $stable(r_reg.bsr)
			|=> pad.data == $past(r_reg.bsr[2*bstap_pkg::NPIN-1:bstap_pkg::NPIN]);
	endproperty
	a_extest: assert property (p_extest) else $error("extest cells not driven"); // [R9]

	property p_tlr_id;
		@(posedge ref_clk) disable iff (rst)
		r_reg.st == bstap_pkg::TLR |=> r_reg.ir == bstap_pkg::OP_IDCODE;
	endproperty
	a_tlr_id: assert property (p_tlr_id) else $error("reset state lost id"); // [R10]

	property p_private;
		@(posedge ref_clk) disable iff (rst)
		s_cap_dr(bstap_pkg::OP_INTSEL) |=> r_reg.dr[0] == 1'b0;
	endproperty
	a_private: assert property (p_private) else $error("private code not bypass"); // [R11]
endmodule

//--- tb/bstap_tester.sv
module bstap_tester (
	// system clock
	input wire logic ref_clk,
	// test lines toward the device
	output logic tck,
	output logic tms,
	output logic tdi,
	// serial answer
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;

	// tck idles low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// one 200 ns tck period, four ref cycles high and four low; tdo is read
	// just after tck rises, while it still holds the bit shown at the last fall
	task automatic step(input logic m, input logic d, output logic o);
		@(posedge ref_clk);
		tms <= m;
		tdi <= d;
		repeat (2) @(posedge ref_clk);
		tck <= 1'b1;
		@(negedge ref_clk);
		o = tdo;
		repeat (4) @(posedge ref_clk);
		tck <= 1'b0;
		@(posedge ref_clk);
	endtask

	// five tms highs reach test-logic-reset, then park in idle
	task automatic reset_tap;
		logic b;
		repeat (5) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask

	// from idle: shift n bits lsb first through ir or dr, update, back to idle
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		step(1'b1, 1'b0, b);
		if (ir) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask
endmodule

//--- tb/boundary_scan_tap_test.sv
module boundary_scan_tap_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic test_mode = 1'b0;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic [bstap_pkg::NPIN-1:0] core_in;
	logic [bstap_pkg::NPIN-1:0] pad_in = 8'hc3;
	bstap_pkg::bstap_pins_t core = 16'h5a0f;
	bstap_pkg::bstap_pins_t pad;
	bstap_pkg::bstap_jtag_t jtag;
	logic [31:0] got;
	int n_errors = 0;
	int total_checks = 0;

	// test port struct assembled from tester lines and the select pin
	assign jtag = {tck, tms, tdi, test_mode};

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	bstap_top u_dut (.ref_clk(ref_clk), .rst(rst), .jtag(jtag), .tdo(tdo),
		.tdo_oe(tdo_oe), .core(core), .core_in(core_in), .pad_in(pad_in), .pad(pad));
	bstap_tester u_tap (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// identification value straight after a tms reset
	task automatic t_ident;
		u_tap.reset_tap();
		u_tap.scan(1'b0, 32'h0, 32, got);
		chk("ident", bstap_pkg::ID_VALUE, got);
	endtask

	// bypass codes, private and unknown codes all give a one-bit path
	task automatic t_bypass;
		logic [15:0] codes [6];
		codes = '{bstap_pkg::OP_BYPASS0, bstap_pkg::OP_BYPASS1, bstap_pkg::OP_CLAMP,
			bstap_pkg::OP_HIGHZ, bstap_pkg::OP_INTSEL, 16'h1234};
		for (int i = 0; i < 6; i++) begin
			u_tap.scan(1'b1, {16'h0, codes[i]}, 16, got);
			chk("ir_capture", {16'h0, bstap_pkg::IR_CAPTURE}, got);
			u_tap.scan(1'b0, 32'hb5, 8, got);
			chk("bypass", 32'h6a, got);
		end
	endtask

	// sample, preload, then drive pins from the boundary cells
	task automatic t_boundary;
		u_tap.scan(1'b1, {16'h0, bstap_pkg::OP_SAMPLE}, 16, got);
		u_tap.scan(1'b0, 32'h3ca500, 24, got);
		chk("capture", {8'h0, core.oe, core.data, pad_in}, got);
		chk("sample_pad", {16'h0, core}, {16'h0, pad});
		u_tap.scan(1'b1, {16'h0, bstap_pkg::OP_EXTEST}, 16, got);
		chk("extest_pad", 32'ha53c, {16'h0, pad});
		u_tap.scan(1'b1, {16'h0, bstap_pkg::OP_HIGHZ}, 16, got);
		chk("highz_oe", 32'h0, {24'h0, pad.oe});
		u_tap.scan(1'b1, {16'h0, bstap_pkg::OP_CLAMP}, 16, got);
		chk("clamp_pad", 32'ha53c, {16'h0, pad});
		u_tap.reset_tap();
		chk("release_pad", {16'h0, core}, {16'h0, pad});
	endtask

	// select pin dropped mid-shift under extest: pins go back to the core,
	// the port goes silent and pin levels still reach the core
	task automatic t_normal;
		logic b;
		u_tap.scan(1'b1, {16'h0, bstap_pkg::OP_EXTEST}, 16, got);
		u_tap.step(1'b1, 1'b0, b);
		u_tap.step(1'b0, 1'b0, b);
		u_tap.step(1'b0, 1'b0, b);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("shift_tdo_oe", 32'h1, {31'h0, tdo_oe});
		chk("extest_hold", 32'ha53c, {16'h0, pad});
		@(posedge ref_clk);
		test_mode <= 1'b0;
		core <= 16'h9966;
		pad_in <= 8'h3c;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("normal_pad", 32'h9966, {16'h0, pad});
		chk("normal_tdo_oe", 32'h0, {31'h0, tdo_oe});
		chk("core_in", 32'h3c, {24'h0, core_in});
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		test_mode <= 1'b1;
		repeat (6) @(posedge ref_clk);
		t_ident();
		t_bypass();
		t_boundary();
		t_normal();
		close_out();
	end

	// cuts a hang short
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end
endmodule
